/* asb_pkg.sv */
// Purpose: Shared constants for the asynchronous serial frame and baud core
// Assumes: Byte-wide register port with a three-bit address
// Notes: Offsets are register indices on the plain port
package asb_pkg;
	// Register offsets
	localparam logic [2:0] ADDR_BAUD_HIGH = 3'h0;
	localparam logic [2:0] ADDR_BAUD_LOW = 3'h1;
	localparam logic [2:0] ADDR_CONTROL = 3'h2;
	localparam logic [2:0] ADDR_STATUS_ONE = 3'h4;
	localparam logic [2:0] ADDR_LINE_STATUS_TWO = 3'h5;
	localparam logic [2:0] ADDR_DATA_HIGH = 3'h6;
	localparam logic [2:0] ADDR_DATA_LOW = 3'h7;
	// Control register fields
	localparam int CTL_NINE_BIT = 0;
	localparam int CTL_PARITY_EN = 1;
	localparam int CTL_PARITY_ODD = 2;
	localparam int CTL_TX_ENABLE = 3;
	localparam int CTL_RX_ENABLE = 4;
	localparam int CTL_SEND_BREAK = 5;
	localparam int CTL_SINGLE_WIRE = 6;
	// Status one fields
	localparam int ST_TX_EMPTY = 7;
	localparam int ST_TX_COMPLETE = 6;
	localparam int ST_RX_FULL = 5;
	localparam int ST_IDLE = 4;
	localparam int ST_OVERRUN = 3;
	localparam int ST_FRAMING = 1;
	localparam int ST_PARITY = 0;
	// Line status two fields
	localparam int LS2_LONG_BREAK = 2;
	localparam int LS2_PIN_DIR = 1;
	localparam int LS2_RX_ACTIVE = 0;
	// High data register fields
	localparam int DH_RX_NINTH = 7;
	localparam int DH_TX_NINTH = 6;
	// Reset values
	localparam logic [7:0] CONTROL_RESET = 8'h00;
	localparam logic [12:0] BAUD_RESET = 13'h0000;
	// Frame timing
	localparam logic [3:0] FRAME_BITS_EIGHT = 4'ha;
	localparam logic [3:0] FRAME_BITS_NINE = 4'hb;
	localparam logic [3:0] LONG_BREAK_EXTRA = 4'h3;
	localparam logic [3:0] LAST_SAMPLE_SLOT = 4'hf;
	localparam logic [3:0] FIRST_SAMPLE_SLOT = 4'h1;
	localparam logic [3:0] MID_SAMPLE_SLOT = 4'h8;
	localparam int CLOCK_PERIOD_NS = 40;
endpackage

/* asb_baud_if.sv */
// Purpose: Carries divisor and baud ticks between the core and its generator
// Assumes: Single clock domain
// Notes: Ticks are one-cycle enables
`timescale 1ns/10ps
interface asb_baud_if #(parameter int DIV_WIDTH = 13);
	logic [DIV_WIDTH-1:0] divisor;
	logic sampleTick;
	logic bitTick;
	modport gen (input divisor, output sampleTick, output bitTick);
	modport user (output divisor, input sampleTick, input bitTick);
endinterface

/* asb_baud_gen.sv */
// Purpose: Modulus divider producing the 16x sample tick and the bit tick
// Assumes: Divisor of zero holds the generator stopped
// Notes: Ticks are registered enables on core_clk
`timescale 1ns/10ps
module asb_baud_gen #(parameter int DIV_WIDTH = 13) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic reset,
	// Divisor and ticks
	asb_baud_if.gen baud
);
	logic [DIV_WIDTH-1:0] modCount_reg;
	logic [3:0] slotCount_reg;

	always_ff @(posedge core_clk) begin
		if (reset || baud.divisor == '0) begin
			modCount_reg <= '0;
			baud.sampleTick <= 1'b0;
		end else if (modCount_reg >= baud.divisor - 1'b1) begin
			modCount_reg <= '0;
			baud.sampleTick <= 1'b1;
		end else begin
			modCount_reg <= modCount_reg + 1'b1;
			baud.sampleTick <= 1'b0;
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset || baud.divisor == '0) begin
			slotCount_reg <= 4'h0;
			baud.bitTick <= 1'b0;
		end else if (baud.sampleTick) begin
			slotCount_reg <= slotCount_reg + 4'h1;
			baud.bitTick <= (slotCount_reg == asb_pkg::LAST_SAMPLE_SLOT);
		end else begin
			baud.bitTick <= 1'b0;
		end
	end
endmodule

/* asb_serial_core.sv */
// Purpose: Register file, transmitter, receiver and baud divisor of a serial port
// Assumes: Plain register port, read data valid one cycle after the strobe
// Notes: Receiver samples once per bit at the middle slot
//
// Implementation choice: the plain strobed port.
`timescale 1ns/10ps
// Overview of operation
// - Line status two writes change only long break and pin direction bits
// - Break is 10 or 11 bits, or 13 or 14 when long break set
// - Framing error check does not depend on long break select
// - Single-wire mode: transmit pin input when direction 0, output when 1
// - Receiver active flag set on a 0 in the first sample slot
// - Receiver active flag cleared when an idle character is seen
// - Data reads return received data; writes load the transmit buffer
// - Writing the received ninth bit position changes nothing
// - High data register gives received and takes transmit ninth bit
// - Transmit ninth bit is kept and reused until rewritten
// - Frame is start, eight or nine data bits, stop
// - Last data bit may be parity or an address mark
// - Thirteen-bit modulus counter divides clock by divisor for both sides
// - Baud clock samples receiver 16 times; transmitter uses it over 16
// - Bit rate is clock over sixteen times divisor
// - Baud clock is made synchronously on the bus clock
// - Transmitter and receiver run independently in full duplex
// - Generator stays disabled while divisor is zero
// - Break character is all zeros with no start or stop bit
module asb_serial_core #(parameter int DIV_WIDTH = 13) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic reset,
	// Register port
	input wire logic [2:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic regWrite,
	input wire logic regRead,
	output logic [7:0] regRdData,
	// Serial pins
	input wire logic rxPin,
	input wire logic txPinIn,
	output logic txPinOut,
	output logic txPinOeN
);
	typedef enum logic [0:0] {RX_SEARCH = 1'b0, RX_FRAME = 1'b1} asb_rx_state_t;

	asb_baud_if #(.DIV_WIDTH(DIV_WIDTH)) baud ();

	logic [7:0] control_reg;
	logic [DIV_WIDTH-1:0] divisor_reg;
	logic [7:0] baudHighHold_reg;
	logic longBreakSelect_reg;
	logic singleWirePinDirection_reg;
	logic receiverActiveFlag_reg;
	logic transmitNinthBit_reg;
	logic [7:0] txBuffer_reg;
	logic receivedNinthBit_reg;
	logic [7:0] rxData_reg;
	logic txEmpty_reg, txComplete_reg;
	logic rxFull_reg, idle_reg, overrun_reg, framing_reg, parity_reg;
	logic [7:0] statusSeen_reg;
	logic [13:0] txShift_reg;
	logic [3:0] txCount_reg;
	logic preamblePending_reg, breakTail_reg, txEnablePrev_reg;
	asb_rx_state_t rxState_reg;
	logic [3:0] rxSlot_reg, rxBitIdx_reg;
	logic [8:0] rxShift_reg;
	logic [7:0] idleSlots_reg;
	logic idleArmed_reg;
	logic [7:0] regRdData_reg;
	logic txPinOeN_reg;

	logic nineBit, parityEn, parityOdd, txEnable, rxEnable, sendBreak, singleWire;
	logic [3:0] frameBits;
	logic rxLine, txLoad, frameDone, rxStopOk;
	logic wrStatusTwo, wrDataHigh, wrDataLow, rdStatusOne, rdDataLow;
	logic [7:0] rxLowNext;
	logic rxNinthNext, rxParityBad;

	// Builds the outgoing shift pattern, lsb first, padded with ones
	function automatic logic [13:0] txFrame(input logic nine, input logic par,
		input logic odd, input logic hi, input logic [7:0] lo);
		logic [8:0] d;
		d = {hi, lo};
		if (par && nine)
			d[8] = (^d[7:0]) ^ odd;
		else if (par)
			d[7] = (^d[6:0]) ^ odd;
		if (!nine)
			d[8] = 1'b1;
		txFrame = {4'hf, d, 1'b0};
	endfunction

	assign nineBit = control_reg[asb_pkg::CTL_NINE_BIT];
	assign parityEn = control_reg[asb_pkg::CTL_PARITY_EN];
	assign parityOdd = control_reg[asb_pkg::CTL_PARITY_ODD];
	assign txEnable = control_reg[asb_pkg::CTL_TX_ENABLE];
	assign rxEnable = control_reg[asb_pkg::CTL_RX_ENABLE];
	assign sendBreak = control_reg[asb_pkg::CTL_SEND_BREAK];
	assign singleWire = control_reg[asb_pkg::CTL_SINGLE_WIRE];
	assign frameBits = nineBit ? asb_pkg::FRAME_BITS_NINE : asb_pkg::FRAME_BITS_EIGHT;

	assign wrStatusTwo = regWrite && regAddr == asb_pkg::ADDR_LINE_STATUS_TWO;
	assign wrDataHigh = regWrite && regAddr == asb_pkg::ADDR_DATA_HIGH;
	assign wrDataLow = regWrite && regAddr == asb_pkg::ADDR_DATA_LOW;
	assign rdStatusOne = regRead && regAddr == asb_pkg::ADDR_STATUS_ONE;
	assign rdDataLow = regRead && regAddr == asb_pkg::ADDR_DATA_LOW;

	// Shared generator, clocked by core_clk
	assign baud.divisor = divisor_reg;
	asb_baud_gen #(.DIV_WIDTH(DIV_WIDTH)) baudGen (
		.core_clk(core_clk),
		.reset(reset),
		.baud(baud)
	);

	// Configuration registers
	always_ff @(posedge core_clk) begin
		if (reset) begin
			control_reg <= asb_pkg::CONTROL_RESET;
			divisor_reg <= asb_pkg::BAUD_RESET;
			baudHighHold_reg <= 8'h00;
		end else if (regWrite) begin
			if (regAddr == asb_pkg::ADDR_CONTROL)
				control_reg <= regWrData;
			if (regAddr == asb_pkg::ADDR_BAUD_HIGH)
				baudHighHold_reg <= regWrData;
			// Divisor takes effect only on the low byte write
			if (regAddr == asb_pkg::ADDR_BAUD_LOW)
				divisor_reg <= DIV_WIDTH'({baudHighHold_reg, regWrData});
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			longBreakSelect_reg <= 1'b0;
			singleWirePinDirection_reg <= 1'b0;
		end else if (wrStatusTwo) begin
			longBreakSelect_reg <= regWrData[asb_pkg::LS2_LONG_BREAK];
			singleWirePinDirection_reg <= regWrData[asb_pkg::LS2_PIN_DIR];
		end
	end

	// Transmit buffer; the received ninth bit is not writable
	always_ff @(posedge core_clk) begin
		if (reset) begin
			transmitNinthBit_reg <= 1'b0;
			txBuffer_reg <= 8'h00;
		end else begin
			if (wrDataHigh)
				transmitNinthBit_reg <= regWrData[asb_pkg::DH_TX_NINTH];
			if (wrDataLow)
				txBuffer_reg <= regWrData;
		end
	end

	// Transmitter shifter, one bit per bit tick
	assign txLoad = baud.bitTick && txCount_reg <= 4'h1;

	always_ff @(posedge core_clk) begin
		if (reset) begin
			txShift_reg <= '1;
			txCount_reg <= 4'h0;
			breakTail_reg <= 1'b0;
		end else if (txLoad) begin
			if (txEnable && sendBreak) begin
				txShift_reg <= '0;
				txCount_reg <= frameBits + (longBreakSelect_reg ? asb_pkg::LONG_BREAK_EXTRA
					: 4'h0);
				breakTail_reg <= 1'b1;
			end else if (breakTail_reg) begin
				txShift_reg <= '1;
				txCount_reg <= 4'h1;
				breakTail_reg <= 1'b0;
			end else if (preamblePending_reg) begin
				txShift_reg <= '1;
				txCount_reg <= frameBits;
			end else if (txEnable && !txEmpty_reg) begin
				txShift_reg <= txFrame(nineBit, parityEn, parityOdd, transmitNinthBit_reg,
					txBuffer_reg);
				txCount_reg <= frameBits;
			end else begin
				txShift_reg <= '1;
				txCount_reg <= 4'h0;
			end
		end else if (baud.bitTick) begin
			txShift_reg <= {1'b1, txShift_reg[13:1]};
			txCount_reg <= txCount_reg - 4'h1;
		end
	end

	// Preamble queued on each rising transmit enable
	always_ff @(posedge core_clk) begin
		if (reset) begin
			txEnablePrev_reg <= 1'b0;
			preamblePending_reg <= 1'b0;
		end else begin
			txEnablePrev_reg <= txEnable;
			if (txEnable && !txEnablePrev_reg)
				preamblePending_reg <= 1'b1;
			else if (txLoad && !(txEnable && sendBreak) && !breakTail_reg)
				preamblePending_reg <= 1'b0;
		end
	end

	// Transmit status; buffer transfer wins over software clear
	always_ff @(posedge core_clk) begin
		if (reset) begin
			txEmpty_reg <= 1'b1;
			txComplete_reg <= 1'b1;
		end else begin
			if (txLoad && txEnable && !sendBreak && !breakTail_reg && !preamblePending_reg
				&& !txEmpty_reg)
				txEmpty_reg <= 1'b1;
			else if (wrDataLow && statusSeen_reg[asb_pkg::ST_TX_EMPTY])
				txEmpty_reg <= 1'b0;
			if (txLoad && txShift_reg[0] && txEmpty_reg && !preamblePending_reg
				&& !sendBreak && !breakTail_reg)
				txComplete_reg <= 1'b1;
			else if (wrDataLow)
				txComplete_reg <= 1'b0;
		end
	end

	// Pin driver and direction
	always_ff @(posedge core_clk) begin
		if (reset)
			txPinOeN_reg <= 1'b1;
		else
			txPinOeN_reg <= !((txEnable || txCount_reg != 4'h0)
				&& (!singleWire || singleWirePinDirection_reg));
	end
	assign txPinOut = txShift_reg[0];
	assign txPinOeN = txPinOeN_reg;

	// Receiver, independent of the transmitter
	assign rxLine = singleWire ? txPinIn : rxPin;
	assign frameDone = baud.sampleTick && rxState_reg == RX_FRAME
		&& rxSlot_reg == asb_pkg::MID_SAMPLE_SLOT && rxBitIdx_reg == frameBits - 4'h1;
	assign rxStopOk = rxLine;
	assign rxLowNext = nineBit ? rxShift_reg[7:0] : rxShift_reg[8:1];
	assign rxNinthNext = nineBit && rxShift_reg[8];
	assign rxParityBad = parityEn && ((^rxLowNext ^ rxNinthNext) != parityOdd);

	always_ff @(posedge core_clk) begin
		if (reset || !rxEnable) begin
			rxState_reg <= RX_SEARCH;
			rxSlot_reg <= 4'h0;
			rxBitIdx_reg <= 4'h0;
			rxShift_reg <= 9'h000;
		end else if (baud.sampleTick) begin
			unique case (rxState_reg)
				RX_SEARCH: begin
					if (!rxLine && !framing_reg) begin
						rxState_reg <= RX_FRAME;
						rxSlot_reg <= asb_pkg::FIRST_SAMPLE_SLOT;
						rxBitIdx_reg <= 4'h0;
					end
				end
				RX_FRAME: begin
					rxSlot_reg <= rxSlot_reg + 4'h1;
					if (rxSlot_reg == asb_pkg::MID_SAMPLE_SLOT) begin
						rxBitIdx_reg <= rxBitIdx_reg + 4'h1;
						if (rxBitIdx_reg == 4'h0 && rxLine)
							rxState_reg <= RX_SEARCH;
						else if (frameDone)
							rxState_reg <= RX_SEARCH;
						else if (rxBitIdx_reg != 4'h0)
							rxShift_reg <= {rxLine, rxShift_reg[8:1]};
					end
				end
			endcase
		end
	end

	// Idle detection: a full frame of ones in sample slots
	always_ff @(posedge core_clk) begin
		if (reset || !rxEnable || !rxLine || rxState_reg == RX_FRAME)
			idleSlots_reg <= 8'h00;
		else if (baud.sampleTick && idleSlots_reg != {frameBits, 4'h0})
			idleSlots_reg <= idleSlots_reg + 8'h01;
	end

	always_ff @(posedge core_clk) begin
		if (reset)
			receiverActiveFlag_reg <= 1'b0;
		else if (baud.sampleTick && rxEnable && rxState_reg == RX_SEARCH && !rxLine)
			receiverActiveFlag_reg <= 1'b1;
		else if (idleSlots_reg == {frameBits, 4'h0})
			receiverActiveFlag_reg <= 1'b0;
	end

	// Receive data and flags; a new event wins over the clear sequence
	always_ff @(posedge core_clk) begin
		if (reset) begin
			rxData_reg <= 8'h00;
			receivedNinthBit_reg <= 1'b0;
			rxFull_reg <= 1'b0;
			overrun_reg <= 1'b0;
			framing_reg <= 1'b0;
			parity_reg <= 1'b0;
			idle_reg <= 1'b0;
			idleArmed_reg <= 1'b0;
		end else begin
			if (frameDone && !rxFull_reg) begin
				rxData_reg <= rxLowNext;
				receivedNinthBit_reg <= rxNinthNext;
				rxFull_reg <= 1'b1;
				framing_reg <= !rxStopOk;
				parity_reg <= rxParityBad;
				idleArmed_reg <= 1'b1;
			end else if (rdDataLow) begin
				if (statusSeen_reg[asb_pkg::ST_RX_FULL])
					rxFull_reg <= 1'b0;
				if (statusSeen_reg[asb_pkg::ST_FRAMING])
					framing_reg <= 1'b0;
				if (statusSeen_reg[asb_pkg::ST_PARITY])
					parity_reg <= 1'b0;
			end
			if (frameDone && rxFull_reg)
				overrun_reg <= 1'b1;
			else if (rdDataLow && statusSeen_reg[asb_pkg::ST_OVERRUN])
				overrun_reg <= 1'b0;
			if (idleArmed_reg && idleSlots_reg == {frameBits, 4'h0}) begin
				idle_reg <= 1'b1;
				idleArmed_reg <= 1'b0;
			end else if (rdDataLow && statusSeen_reg[asb_pkg::ST_IDLE])
				idle_reg <= 1'b0;
		end
	end

	// Flags seen set by the last status read arm the clear
	always_ff @(posedge core_clk) begin
		if (reset)
			statusSeen_reg <= 8'h00;
		else if (rdStatusOne)
			statusSeen_reg <= {txEmpty_reg, txComplete_reg, rxFull_reg, idle_reg, overrun_reg,
				1'b0, framing_reg, parity_reg};
		else if (rdDataLow || wrDataLow)
			statusSeen_reg <= 8'h00;
	end

	// Read data valid only in the cycle after the strobe
	always_ff @(posedge core_clk) begin
		if (reset || !regRead) begin
			regRdData_reg <= 8'h00;
		end else begin
			unique case (regAddr)
				asb_pkg::ADDR_BAUD_HIGH:
					regRdData_reg <= 8'(divisor_reg >> 8);
				asb_pkg::ADDR_BAUD_LOW:
					regRdData_reg <= divisor_reg[7:0];
				asb_pkg::ADDR_CONTROL:
					regRdData_reg <= control_reg;
				asb_pkg::ADDR_STATUS_ONE:
					regRdData_reg <= {txEmpty_reg, txComplete_reg, rxFull_reg, idle_reg,
						overrun_reg, 1'b0, framing_reg, parity_reg};
				asb_pkg::ADDR_LINE_STATUS_TWO:
					regRdData_reg <= {5'h00, longBreakSelect_reg, singleWirePinDirection_reg,
						receiverActiveFlag_reg};
				asb_pkg::ADDR_DATA_HIGH:
					regRdData_reg <= {receivedNinthBit_reg, 7'h00};
				asb_pkg::ADDR_DATA_LOW:
					regRdData_reg <= rxData_reg;
				default:
					regRdData_reg <= 8'h00;
			endcase
		end
	end
	assign regRdData = regRdData_reg;
endmodule

/* asb_remote_dev.sv */
// Purpose: Remote serial device on the line side
// Assumes: Bit time is a whole number of core clocks
// Notes: Line idles high between frames
`timescale 1ns/10ps
module asb_remote_dev #(parameter int BIT_CYC = 16) (
	// Clock
	input wire logic core_clk,
	// Line
	input wire logic txLine,
	output logic rxLine
);
	initial rxLine = 1'b1;
	task automatic send(input logic [10:0] bits, input int n);
		for (int i = 0; i < n; i++) begin
			rxLine <= bits[i];
			repeat (BIT_CYC) @(posedge core_clk);
		end
		rxLine <= 1'b1;
	endtask
	task automatic grab(output logic [10:0] bits, input int n);
		int k;
		bits = 11'h000;
		k = 0;
		while (txLine !== 1'b0 && k < 4000) begin
			@(posedge core_clk);
			#1;
			k++;
		end
		repeat (BIT_CYC / 2) @(posedge core_clk);
		#1;
		for (int i = 0; i < n; i++) begin
			bits[i] = txLine;
			repeat (BIT_CYC) @(posedge core_clk);
			#1;
		end
	endtask
endmodule

/* asb_serial_core_chk.sv */
// Purpose: Port checker for the serial core
// Assumes: Single clock, synchronous reset
// Notes: Shadows follow register writes
`timescale 1ns/10ps
module asb_serial_core_chk (
	// Clock and reset
	input wire logic core_clk,
	input wire logic reset,
	// Register port
	input wire logic [2:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic regWrite,
	input wire logic regRead,
	input wire logic [7:0] regRdData,
	// Serial pins
	input wire logic rxPin,
	input wire logic txPinIn,
	input wire logic txPinOut,
	input wire logic txPinOeN
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);
	logic [7:0] ctl_reg;
	logic [7:0] hi_reg;
	logic [1:0] ls2_reg;
	logic [12:0] div_reg;
	logic seen_reg;
	logic [15:0] run_reg;
	logic edge_reg;
	logic baudWr;
	assign baudWr = regWrite && regAddr == asb_pkg::ADDR_BAUD_LOW;
	always_ff @(posedge core_clk) begin
		if (reset) begin
			ctl_reg <= 8'h00;
			hi_reg <= 8'h00;
			ls2_reg <= 2'h0;
		end else if (regWrite) begin
			if (regAddr == asb_pkg::ADDR_CONTROL) ctl_reg <= regWrData;
			if (regAddr == asb_pkg::ADDR_BAUD_HIGH) hi_reg <= regWrData;
			if (regAddr == asb_pkg::ADDR_LINE_STATUS_TWO) ls2_reg <= regWrData[2:1];
		end
	end
	always_ff @(posedge core_clk) begin
		if (reset) begin
			div_reg <= 13'h0000;
			seen_reg <= 1'b0;
		end else if (baudWr) begin
			div_reg <= {hi_reg[4:0], regWrData};
			seen_reg <= 1'b1;
		end
	end
	always_ff @(posedge core_clk) begin
		if (reset || baudWr) begin
			run_reg <= 16'h0001;
			edge_reg <= 1'b0;
		end else if ($changed(txPinOut)) begin
			run_reg <= 16'h0001;
			edge_reg <= 1'b1;
		end else begin
			run_reg <= run_reg + 16'h0001;
		end
	end
	AST_IDLE_RDATA: assert property (!regRead |=> regRdData == 8'h00)
		else $error("read data not zero outside read slot");
	AST_LS2_FIELDS: assert property (regRead && regAddr == asb_pkg::ADDR_LINE_STATUS_TWO
		|=> regRdData[7:1] == {5'h00, $past(ls2_reg)}) else $error("line status two mismatch");
	AST_DH_LAYOUT: assert property (regRead && regAddr == asb_pkg::ADDR_DATA_HIGH
		|=> regRdData[6:0] == 7'h00) else $error("data high low bits not zero");
	AST_HOLE_ZERO: assert property (regRead && regAddr == 3'h3 |=> regRdData == 8'h00)
		else $error("unmapped read not zero");
	AST_SW_INPUT: assert property (ctl_reg[6] && !ls2_reg[0] && $past(ctl_reg[6])
		&& !$past(ls2_reg[0]) |-> txPinOeN) else $error("pin driven while input");
	AST_NO_BAUD_IDLE: assert property (!seen_reg |-> txPinOut)
		else $error("line moved without divisor");
	AST_BIT_SPACING: assert property (edge_reg && $changed(txPinOut) && div_reg != 13'h0000
		|-> (32'(run_reg) % (16 * 32'(div_reg))) == 0) else $error("bit edge off grid");
	AST_RESET_IDLE: assert property ($fell(reset) |-> txPinOut && txPinOeN
		&& regRdData == 8'h00) else $error("outputs not idle after reset");
	COV_LS2_READ: cover property (regRead && regAddr == asb_pkg::ADDR_LINE_STATUS_TWO);
	COV_LONG_LOW: cover property (edge_reg && $rose(txPinOut) && run_reg == 16'h00d0);
	COV_SW_DRIVE: cover property (ctl_reg[6] && !txPinOeN);
endmodule

/* testbench.sv */
// Purpose: Self-checking bench for the serial core
// Assumes: Divisor one, so a bit is 16 clocks
// Notes: Remote device model drives the receive line
`timescale 1ns/10ps
module testbench;
	logic core_clk = 1'b0;
	logic reset = 1'b1;
	logic [2:0] regAddr = 3'h0;
	logic [7:0] regWrData = 8'h00;
	logic regWrite = 1'b0;
	logic regRead = 1'b0;
	logic [7:0] regRdData;
	logic rxPin, txPinIn, txPinOut, txPinOeN;
	logic [10:0] got;
	int error_cnt = 0;
	int cmp_count = 0;
	assign txPinIn = txPinOeN ? rxPin : txPinOut;
	always #20 core_clk = ~core_clk;
	asb_serial_core i_dut (.core_clk(core_clk), .reset(reset), .regAddr(regAddr),
		.regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
		.rxPin(rxPin), .txPinIn(txPinIn), .txPinOut(txPinOut), .txPinOeN(txPinOeN));
	asb_remote_dev #(.BIT_CYC(16)) i_dev (.core_clk(core_clk), .txLine(txPinOut), .rxLine(rxPin));
	task automatic chk(input logic [10:0] g, input logic [10:0] e);
		cmp_count++;
		if (g !== e) begin
			error_cnt++;
			$display("unexpected at %0t: got %h want %h", $time, g, e);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge core_clk);
		regAddr <= a;
		regWrData <= d;
		regWrite <= 1'b1;
		@(posedge core_clk);
		regWrite <= 1'b0;
	endtask
	task automatic rd(input logic [2:0] a, input logic [7:0] m, input logic [7:0] e);
		@(posedge core_clk);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge core_clk);
		regRead <= 1'b0;
		#1;
		chk({3'h0, regRdData & m}, {3'h0, e});
	endtask
	task automatic t_regs();
		wr(asb_pkg::ADDR_LINE_STATUS_TWO, 8'hff);
		rd(asb_pkg::ADDR_LINE_STATUS_TWO, 8'hfe, 8'h06);
		rd(3'h3, 8'hff, 8'h00);
		wr(asb_pkg::ADDR_LINE_STATUS_TWO, 8'h00);
		rd(asb_pkg::ADDR_LINE_STATUS_TWO, 8'hfe, 8'h00);
		wr(asb_pkg::ADDR_BAUD_HIGH, 8'h00);
		wr(asb_pkg::ADDR_BAUD_LOW, 8'h01);
		wr(asb_pkg::ADDR_CONTROL, 8'h18);
	endtask
	task automatic t_tx();
		rd(asb_pkg::ADDR_STATUS_ONE, 8'h80, 8'h80);
		wr(asb_pkg::ADDR_DATA_LOW, 8'ha5);
		i_dev.grab(got, 10);
		chk(got, {1'b0, 1'b1, 8'ha5, 1'b0});
		wr(asb_pkg::ADDR_CONTROL, 8'h19);
		rd(asb_pkg::ADDR_STATUS_ONE, 8'h80, 8'h80);
		wr(asb_pkg::ADDR_DATA_HIGH, 8'h40);
		wr(asb_pkg::ADDR_DATA_LOW, 8'h3c);
		i_dev.grab(got, 11);
		chk(got, {1'b1, 1'b1, 8'h3c, 1'b0});
		rd(asb_pkg::ADDR_DATA_HIGH, 8'h7f, 8'h00);
		rd(asb_pkg::ADDR_STATUS_ONE, 8'h80, 8'h80);
		wr(asb_pkg::ADDR_DATA_LOW, 8'h00);
		i_dev.grab(got, 11);
		chk(got, {1'b1, 1'b1, 8'h00, 1'b0});
	endtask
	task automatic t_duplex();
		logic [10:0] txGot;
		rd(asb_pkg::ADDR_STATUS_ONE, 8'h80, 8'h80);
		wr(asb_pkg::ADDR_DATA_LOW, 8'hc3);
		fork
			i_dev.send({1'b1, 1'b1, 8'h5a, 1'b0}, 11);
			i_dev.grab(txGot, 11);
			begin
				tick(40);
				rd(asb_pkg::ADDR_LINE_STATUS_TWO, 8'h01, 8'h01);
			end
		join
		chk(txGot, {1'b1, 1'b1, 8'hc3, 1'b0});
		tick(220);
		rd(asb_pkg::ADDR_LINE_STATUS_TWO, 8'h01, 8'h00);
		rd(asb_pkg::ADDR_STATUS_ONE, 8'h20, 8'h20);
		rd(asb_pkg::ADDR_DATA_HIGH, 8'h80, 8'h80);
		wr(asb_pkg::ADDR_DATA_HIGH, 8'h00);
		rd(asb_pkg::ADDR_DATA_HIGH, 8'h80, 8'h80);
		rd(asb_pkg::ADDR_DATA_LOW, 8'hff, 8'h5a);
	endtask
	task automatic t_parity();
		wr(asb_pkg::ADDR_CONTROL, 8'h1e);
		rd(asb_pkg::ADDR_STATUS_ONE, 8'h80, 8'h80);
		wr(asb_pkg::ADDR_DATA_LOW, 8'hb1);
		fork
			i_dev.send({2'b01, 8'hb1, 1'b0}, 10);
			i_dev.grab(got, 10);
		join
		chk(got, {1'b0, 1'b1, 8'h31, 1'b0});
		rd(asb_pkg::ADDR_STATUS_ONE, 8'h21, 8'h21);
		rd(asb_pkg::ADDR_DATA_LOW, 8'hff, 8'hb1);
		wr(asb_pkg::ADDR_CONTROL, 8'h1a);
		wr(asb_pkg::ADDR_LINE_STATUS_TWO, 8'h04);
		i_dev.send({2'b00, 8'h00, 1'b0}, 10);
		rd(asb_pkg::ADDR_STATUS_ONE, 8'h23, 8'h22);
		rd(asb_pkg::ADDR_DATA_LOW, 8'hff, 8'h00);
	endtask
	task automatic t_break(input logic [7:0] ls2, input int bits);
		int n;
		wr(asb_pkg::ADDR_LINE_STATUS_TWO, ls2);
		wr(asb_pkg::ADDR_CONTROL, 8'h38);
		n = 0;
		while (txPinOut !== 1'b0 && n < 2000) begin
			tick(1);
			n++;
		end
		wr(asb_pkg::ADDR_CONTROL, 8'h18);
		#1;
		n = 2;
		while (txPinOut === 1'b0 && n < 1000) begin
			tick(1);
			n++;
		end
		chk(11'(n), 11'(bits * 16));
		tick(40);
	endtask
	task automatic t_single();
		wr(asb_pkg::ADDR_CONTROL, 8'h48);
		tick(3);
		chk({10'h000, txPinOeN}, 11'h001);
		wr(asb_pkg::ADDR_LINE_STATUS_TWO, 8'h02);
		tick(3);
		chk({10'h000, txPinOeN}, 11'h000);
	endtask
	task automatic conclude();
		$display("errors %0d compares %0d", error_cnt, cmp_count);
		if (error_cnt == 0 && cmp_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial begin
		repeat (16) @(posedge core_clk);
		reset <= 1'b0;
		t_regs();
		t_tx();
		t_duplex();
		t_parity();
		t_break(8'h00, 10);
		t_break(8'h04, 13);
		t_single();
		conclude();
	end
	initial begin
		repeat (30000) @(posedge core_clk);
		error_cnt++;
		conclude();
	end
endmodule
bind asb_serial_core asb_serial_core_chk i_chk (.core_clk(core_clk), .reset(reset),
	.regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
	.regRdData(regRdData), .rxPin(rxPin), .txPinIn(txPinIn), .txPinOut(txPinOut),
	.txPinOeN(txPinOeN));
